//--- dacd_pkg.sv
package dacd_pkg;
    // input configuration as decoded for one conversion
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_FULL_DIFF,
        MODE_OFFSET_PAIR
    } dacd_mode_t;

    typedef struct packed {
        dacd_mode_t mode;
        logic [2:0] pos_sel;     // positive input index, 0..5
        logic       neg_is_gnd;  // negative input tied to analog ground
        logic [2:0] neg_sel;     // negative input index when not ground
        logic       range_dbl;   // span 0..2*vref
        logic       twos_comp;   // output coding twos complement
        logic [1:0] lsb_shift;   // lsb = vref/4096 << lsb_shift
    } dacd_cfg_t;

    localparam int         LSB_DIVISOR      = 4096;
    localparam logic [4:0] TRACK_EDGE_COUNT = 5'h0d;  // 13th rising sclk edge
    localparam logic [4:0] RANGE_HOLD_FALLS = 5'h03;  // range latched by 3rd fall
    localparam int         ACQ_TIME_NS      = 290;
    localparam int         CLK_PERIOD_NS    = 5;
    localparam logic [7:0] ACQ_CYCLES       = 8'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam dacd_cfg_t  CFG_RESET        = '{MODE_FULL_DIFF, 3'h0, 1'b0, 3'h1,
                                                1'b0, 1'b1, 2'h1};
endpackage

//--- dacd_config_decode.sv
`timescale 1ns/1ps
// Contract
// - select low groups each converter's six inputs into three differential pairs.
// - select high makes the six inputs single-ended against analog ground.
// - track-and-hold returns to track on the 13th sclk rise after cs falls.
// - an address change that alters the input type restarts the acquisition time.
// - range low gives span 0..vref, range high gives 0..2*vref.
// - fully differential or double range conversions use twos-complement coding.
// - straight binary only for single-ended or offset pairs in the single range, per conversion.
// - single-ended codes 0..5 pick inputs 1..6 of both converters with ground negative.
// - differential upper address bits pick pairs 1/2, 3/4, 5/6; bit 0 picks offset pair.
// - lsb is vref/4096 scaled by 1, 2 or 4 by input type and range.
// - both inputs are sampled and conversion starts at the cs falling edge.
module dacd_config_decode
    import dacd_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      cs_n,
    input  wire logic      sclk,
    input  wire logic      input_type_select,
    input  wire logic      chan_addr_bit0,
    input  wire logic      chan_addr_bit1,
    input  wire logic      chan_addr_bit2,
    input  wire logic      range_sel,
    output dacd_cfg_t      live_cfg_ff,
    output dacd_cfg_t      conv_cfg_ff,
    output logic           track_ff,
    output logic           acq_done_ff,
    output logic           sample_ff,
    output logic           conv_active_ff
);

    // decode pins into a configuration
    function automatic dacd_cfg_t decode_cfg(input logic sgl, input logic [2:0] addr,
                                              input logic rng);
        dacd_cfg_t c;
        c = CFG_RESET;
        c.range_dbl = rng;
        if (sgl) begin
            c.mode       = MODE_SINGLE;
            c.pos_sel    = addr;  // codes 6,7 pass through as don't-care
            c.neg_is_gnd = 1'b1;
            c.neg_sel    = 3'h0;
        end else begin
            c.mode       = addr[0] ? MODE_OFFSET_PAIR : MODE_FULL_DIFF;
            c.pos_sel    = {addr[2:1], 1'b0};
            c.neg_is_gnd = 1'b0;
            c.neg_sel    = {addr[2:1], 1'b1};
        end
        c.twos_comp = (c.mode == MODE_FULL_DIFF) || rng;
        // lsb scaling, differential types double it
        c.lsb_shift = 2'({1'b0, rng} + {1'b0, !sgl});
        return c;
    endfunction

    // two-flop synchronisers for all pins
    logic [6:0] meta_ff;
    logic [6:0] sync_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // idle pin levels (cs_n and sclk high) so no false edge follows reset
            meta_ff <= 7'h60;
            sync_ff <= 7'h60;
        end else begin
            meta_ff <= {cs_n, sclk, input_type_select, chan_addr_bit2, chan_addr_bit1,
                        chan_addr_bit0, range_sel};
            sync_ff <= meta_ff;
        end
    end

    logic       s_cs_n;
    logic       s_sclk;
    logic       s_sgl;
    logic [2:0] s_addr;
    logic       s_rng;
    assign s_cs_n = sync_ff[6];
    assign s_sclk = sync_ff[5];
    assign s_sgl  = sync_ff[4];
    assign s_addr = sync_ff[3:1];
    assign s_rng  = sync_ff[0];

    dacd_cfg_t  live_now;
    assign live_now = decode_cfg(s_sgl, s_addr, s_rng);

    // state registers
    logic       cs_d_ff;
    logic       sclk_d_ff;
    logic [4:0] rise_cnt_ff;
    logic [4:0] fall_cnt_ff;
    logic [7:0] acq_cnt_ff;
    logic       rng_lat_ff;

    logic       nxt_cs_d;
    logic       nxt_sclk_d;
    logic [4:0] nxt_rise_cnt;
    logic [4:0] nxt_fall_cnt;
    logic [7:0] nxt_acq_cnt;
    logic       nxt_rng_lat;
    dacd_cfg_t  nxt_live_cfg;
    dacd_cfg_t  nxt_conv_cfg;
    logic       nxt_track;
    logic       nxt_acq_done;
    logic       nxt_sample;
    logic       nxt_conv_active;

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic type_change;
    assign cs_fall   = cs_d_ff && !s_cs_n;
    assign cs_rise   = !cs_d_ff && s_cs_n;
    assign sclk_rise = !sclk_d_ff && s_sclk;
    assign sclk_fall = sclk_d_ff && !s_sclk;
    assign type_change = live_now.mode != live_cfg_ff.mode;

    // next-state computation for the conversion sequencer
    always_comb begin
        nxt_cs_d        = s_cs_n;
        nxt_sclk_d      = s_sclk;
        nxt_rise_cnt    = rise_cnt_ff;
        nxt_fall_cnt    = fall_cnt_ff;
        nxt_acq_cnt     = acq_cnt_ff;
        nxt_rng_lat     = rng_lat_ff;
        nxt_live_cfg    = live_now;
        nxt_conv_cfg    = conv_cfg_ff;
        nxt_track       = track_ff;
        nxt_acq_done    = acq_done_ff;
        nxt_sample      = 1'b0;
        nxt_conv_active = conv_active_ff;
        // acquisition timer runs while tracking
        if (track_ff && acq_cnt_ff != ACQ_CYCLES) begin
            nxt_acq_cnt = acq_cnt_ff + 8'h01;
        end
        if (type_change) begin
            nxt_acq_cnt = 8'h00;
        end
        nxt_acq_done = (nxt_acq_cnt == ACQ_CYCLES);
        if (cs_fall) begin
            // sample and freeze selection at cs fall
            nxt_sample      = 1'b1;
            nxt_conv_active = 1'b1;
            nxt_track       = 1'b0;
            nxt_rise_cnt    = 5'h00;
            nxt_fall_cnt    = 5'h00;
            nxt_rng_lat     = s_rng;
            nxt_conv_cfg    = live_now;
            nxt_acq_cnt     = 8'h00;
            nxt_acq_done    = 1'b0;
        end else if (conv_active_ff) begin
            if (sclk_rise && rise_cnt_ff != 5'h1f) begin
                nxt_rise_cnt = rise_cnt_ff + 5'h01;
            end
            if (sclk_fall && fall_cnt_ff != 5'h1f) begin
                nxt_fall_cnt = fall_cnt_ff + 5'h01;
            end
            // range sampled until the 3rd sclk fall
            if (fall_cnt_ff < RANGE_HOLD_FALLS) begin
                nxt_rng_lat = s_rng;
                nxt_conv_cfg = decode_cfg(conv_cfg_ff.mode == MODE_SINGLE,
                                          {conv_cfg_ff.pos_sel[2:1],
                                           conv_cfg_ff.mode == MODE_SINGLE ?
                                           conv_cfg_ff.pos_sel[0] :
                                           conv_cfg_ff.mode == MODE_OFFSET_PAIR},
                                          s_rng);
            end
            // back to track on 13th rising edge
            if (sclk_rise && rise_cnt_ff == TRACK_EDGE_COUNT - 5'h01) begin
                nxt_track = 1'b1;
            end
            if (cs_rise) begin
                nxt_conv_active = 1'b0;
                nxt_track       = 1'b1;
            end
        end else begin
            nxt_track = 1'b1;
        end
    end

    // register the sequencer state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_d_ff        <= 1'b1;
            sclk_d_ff      <= 1'b1;
            rise_cnt_ff    <= 5'h00;
            fall_cnt_ff    <= 5'h00;
            acq_cnt_ff     <= 8'h00;
            rng_lat_ff     <= 1'b0;
            live_cfg_ff    <= CFG_RESET;
            conv_cfg_ff    <= CFG_RESET;
            track_ff       <= 1'b1;
            acq_done_ff    <= 1'b0;
            sample_ff      <= 1'b0;
            conv_active_ff <= 1'b0;
        end else begin
            cs_d_ff        <= nxt_cs_d;
            sclk_d_ff      <= nxt_sclk_d;
            rise_cnt_ff    <= nxt_rise_cnt;
            fall_cnt_ff    <= nxt_fall_cnt;
            acq_cnt_ff     <= nxt_acq_cnt;
            rng_lat_ff     <= nxt_rng_lat;
            live_cfg_ff    <= nxt_live_cfg;
            conv_cfg_ff    <= nxt_conv_cfg;
            track_ff       <= nxt_track;
            acq_done_ff    <= nxt_acq_done;
            sample_ff      <= nxt_sample;
            conv_active_ff <= nxt_conv_active;
        end
    end

    // assertions
    // track returns on 13th rise
    track_edge_a: assert property (@(posedge clk) disable iff (rst)
        conv_active_ff && !cs_fall && !cs_rise && sclk_rise &&
        rise_cnt_ff == 5'h0c |=> track_ff)
        else $error("track not restored at 13th sclk rise");
    sample_start_a: assert property (@(posedge clk) disable iff (rst)
        cs_fall |=> sample_ff && conv_active_ff && !track_ff)
        else $error("cs fall did not start conversion");
    single_gnd_a: assert property (@(posedge clk) disable iff (rst)
        live_cfg_ff.mode == MODE_SINGLE |-> live_cfg_ff.neg_is_gnd)
        else $error("single-ended negative not ground");
    single_sel_a: assert property (@(posedge clk) disable iff (rst)
        s_sgl |=> live_cfg_ff.pos_sel == $past(s_addr))
        else $error("single-ended input mismatch");
    diff_pair_a: assert property (@(posedge clk) disable iff (rst)
        !s_sgl |=> !live_cfg_ff.neg_is_gnd &&
        live_cfg_ff.neg_sel == live_cfg_ff.pos_sel + 3'h1)
        else $error("differential pair wrong");
    offset_pair_a: assert property (@(posedge clk) disable iff (rst)
        !s_sgl && s_addr[0] |=> live_cfg_ff.mode == MODE_OFFSET_PAIR)
        else $error("offset pair not selected");
    twos_code_a: assert property (@(posedge clk) disable iff (rst)
        live_cfg_ff.mode == MODE_FULL_DIFF || live_cfg_ff.range_dbl |-> live_cfg_ff.twos_comp)
        else $error("twos complement expected");
    binary_code_a: assert property (@(posedge clk) disable iff (rst)
        live_cfg_ff.mode != MODE_FULL_DIFF && !live_cfg_ff.range_dbl |-> !live_cfg_ff.twos_comp)
        else $error("straight binary expected");
    acq_restart_a: assert property (@(posedge clk) disable iff (rst)
        type_change && !cs_fall |=> acq_cnt_ff == 8'h00 && !acq_done_ff)
        else $error("acquisition not restarted");
    lsb_scale_a: assert property (@(posedge clk) disable iff (rst)
        live_cfg_ff.lsb_shift == 2'({1'b0, live_cfg_ff.range_dbl} +
        {1'b0, live_cfg_ff.mode != MODE_SINGLE}))
        else $error("lsb scale wrong");
    range_live_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> live_cfg_ff.range_dbl == $past(s_rng))
        else $error("range not followed");
    sample_pulse_a: assert property (@(posedge clk) disable iff (rst)
        sample_ff |=> !sample_ff)
        else $error("sample pulse longer than one cycle");
    idle_track_a: assert property (@(posedge clk) disable iff (rst)
        !conv_active_ff && !cs_fall |=> track_ff)
        else $error("not tracking while idle");
    conv_freeze_a: assert property (@(posedge clk) disable iff (rst)
        conv_active_ff && !cs_fall |=> $stable(conv_cfg_ff.mode) &&
        $stable(conv_cfg_ff.pos_sel))
        else $error("selection changed during conversion");
    range_freeze_a: assert property (@(posedge clk) disable iff (rst)
        conv_active_ff && !cs_fall && fall_cnt_ff >= RANGE_HOLD_FALLS |=>
        $stable(conv_cfg_ff.range_dbl) && $stable(conv_cfg_ff.twos_comp))
        else $error("range moved after third sclk fall");
    track_hold_a: assert property (@(posedge clk) disable iff (rst)
        conv_active_ff && !cs_rise && rise_cnt_ff < TRACK_EDGE_COUNT - 5'h01 |=> !track_ff)
        else $error("track returned too early");
    conv_twos_a: assert property (@(posedge clk) disable iff (rst)
        conv_cfg_ff.mode == MODE_FULL_DIFF || conv_cfg_ff.range_dbl |->
        conv_cfg_ff.twos_comp)
        else $error("conversion twos complement expected");
    conv_binary_a: assert property (@(posedge clk) disable iff (rst)
        conv_cfg_ff.mode != MODE_FULL_DIFF && !conv_cfg_ff.range_dbl |->
        !conv_cfg_ff.twos_comp)
        else $error("conversion straight binary expected");
    acq_count_a: assert property (@(posedge clk) disable iff (rst)
        acq_done_ff |-> acq_cnt_ff == ACQ_CYCLES)
        else $error("acquisition done before full count");

endmodule

//--- dacd_host_model.sv
`timescale 1ns/1ps
// host side of the pins: everything changes on the clk fall
module dacd_host_model
    import dacd_pkg::*;
(
    input  wire logic       clk,
    output logic            cs_n,
    output logic            sclk,
    output logic            input_type_select,
    output logic [2:0]      addr,
    output logic            range_sel
);
    // sclk idles high and only toggles inside a frame
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        input_type_select = 1'b0;
        addr = 3'h0;
        range_sel = 1'b0;
    end

    // new pin levels, no waiting
    task automatic pins(input logic s, input logic [2:0] a, input logic r);
        @(negedge clk);
        input_type_select = s;
        addr = a;
        range_sel = r;
    endtask

    // pins settle one acquisition time before the frame
    task automatic setup(input logic s, input logic [2:0] a, input logic r);
        pins(s, a, r);
        repeat (ACQ_CYCLES + 8) @(negedge clk);
    endtask

    // frame edge; select is never touched while cs_n is low
    task automatic frame(input logic on);
        @(negedge clk);
        cs_n = ~on;
        repeat (6) @(negedge clk);
    endtask

    // four clk per sclk phase keeps the synchroniser ahead of the pins
    task automatic pulses(input int n);
        repeat (n) begin
            sclk = 1'b0;
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            repeat (4) @(negedge clk);
        end
    endtask
endmodule

//--- dual_adc_input_config_decode_tb.sv
`timescale 1ns/1ps
module dual_adc_input_config_decode_tb;
    import dacd_pkg::*;
    logic       clk;
    logic       rst;
    logic       cs_n;
    logic       sclk;
    logic       sel;
    logic [2:0] addr;
    logic       rng;
    dacd_cfg_t  live;
    dacd_cfg_t  conv;
    logic       track;
    logic       acq;
    logic       sample;
    logic       active;
    int         miscompares;
    int         check_count;
    int         samples;
    int         cyc;

    dacd_host_model u_dacd_host_model (.clk(clk), .cs_n(cs_n), .sclk(sclk),
        .input_type_select(sel), .addr(addr), .range_sel(rng));
    dacd_config_decode u_dacd_config_decode (.clk(clk), .rst(rst), .cs_n(cs_n),
        .sclk(sclk), .input_type_select(sel), .chan_addr_bit0(addr[0]),
        .chan_addr_bit1(addr[1]), .chan_addr_bit2(addr[2]), .range_sel(rng),
        .live_cfg_ff(live), .conv_cfg_ff(conv), .track_ff(track),
        .acq_done_ff(acq), .sample_ff(sample), .conv_active_ff(active));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // counts sample pulses and cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (sample === 1'b1) samples++;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic summarize;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // every type, addresses 0..5 and both ranges, judged on the live decode
    task automatic t_decode;
        logic s;
        logic r;
        logic [2:0] a;
        logic [2:0] ps;
        dacd_mode_t md;
        for (int k = 0; k < 24; k++) begin
            s = (k >= 12);
            a = 3'((k / 2) % 6);
            r = k[0];
            md = s ? MODE_SINGLE : (a[0] ? MODE_OFFSET_PAIR : MODE_FULL_DIFF);
            ps = s ? a : {a[2:1], 1'b0};
            u_dacd_host_model.pins(s, a, r);
            repeat (6) @(negedge clk);
            chk(live.mode === md, "mode");
            chk(live.pos_sel === ps && live.neg_is_gnd === s, "inputs");
            chk(s || live.neg_sel === ps + 3'h1, "pair");
            chk(live.range_dbl === r, "range");
            chk(live.twos_comp === (r | (md == MODE_FULL_DIFF)), "coding");
            chk(live.lsb_shift === {1'b0, r} + {1'b0, ~s}, "lsb");
        end
        $display("t_decode done");
    endtask

    // one frame; range flips after the 3rd fall and must not leak in
    task automatic t_conv(input logic s, input logic [2:0] a, input logic r);
        int n;
        dacd_mode_t md;
        md = s ? MODE_SINGLE : (a[0] ? MODE_OFFSET_PAIR : MODE_FULL_DIFF);
        u_dacd_host_model.setup(s, a, r);
        chk(acq === 1'b1 && track === 1'b1, "acq");
        n = samples;
        u_dacd_host_model.frame(1'b1);
        chk(samples == n + 1 && active === 1'b1 && track === 1'b0, "start");
        u_dacd_host_model.pulses(3);
        u_dacd_host_model.pins(s, a, ~r);
        u_dacd_host_model.pulses(9);
        chk(track === 1'b0, "early track");
        chk(conv.range_dbl === r && conv.pos_sel === (s ? a : {a[2:1], 1'b0}), "frozen");
        chk(conv.twos_comp === (r | (~s & ~a[0])), "conv coding");
        chk(conv.mode === md, "conv mode");
        chk(conv.neg_is_gnd === s, "conv ground");
        chk(s || conv.neg_sel === {a[2:1], 1'b1}, "conv pair");
        chk(conv.lsb_shift === 2'({1'b0, r} + {1'b0, ~s}), "conv lsb");
        u_dacd_host_model.pulses(1);
        chk(track === 1'b1, "track");
        u_dacd_host_model.frame(1'b0);
        chk(active === 1'b0 && samples == n + 1, "end");
        $display("t_conv done");
    endtask

    // type change restarts acquisition, pair change within type does not
    task automatic t_restart;
        u_dacd_host_model.setup(1'b0, 3'h1, 1'b0);
        u_dacd_host_model.pins(1'b0, 3'h3, 1'b0);
        repeat (6) @(negedge clk);
        chk(acq === 1'b1, "same type");
        u_dacd_host_model.pins(1'b0, 3'h2, 1'b0);
        repeat (6) @(negedge clk);
        chk(acq === 1'b0, "restart");
        repeat (ACQ_CYCLES - 12) @(negedge clk);
        chk(acq === 1'b0, "still acquiring");
        repeat (20) @(negedge clk);
        chk(acq === 1'b1, "acquired");
        $display("t_restart done");
    endtask

    initial begin
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk(live === CFG_RESET && conv === CFG_RESET && track === 1'b1, "reset");
        t_decode();
        t_conv(1'b1, 3'h4, 1'b1);
        t_conv(1'b0, 3'h1, 1'b0);
        t_conv(1'b0, 3'h2, 1'b0);
        t_restart();
        summarize();
    end
endmodule
